/* shbtp_port.sv */
`timescale 1ns/1ps
module shbtp_port
    import shbtp_pkg::*;
#(
    parameter int ARB_LAT = ARB_LAT_DEF,
    parameter int DEPTH_W = 6
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // Configuration straps
    input  wire logic              endian_profile_strap,
    input  wire logic              stall_polarity_strap,
    input  wire logic              clock_divide_strap,
    // Host bus
    input  wire logic              chip_select_n,
    input  wire logic [ADDR_W-1:0] port_address,
    input  wire logic              mem_reg_select,
    input  wire logic              low_byte_write_n,
    input  wire logic              high_byte_write_n,
    input  wire logic              low_read_n,
    input  wire logic              high_read_n,
    input  wire logic              bus_start_unused,
    input  wire logic [DATA_W-1:0] port_data_in,
    output logic      [DATA_W-1:0] port_data_out,
    output logic                   port_data_oe_n,
    output logic                   stall_out,
    output logic                   stall_oe_n,
    // Internal arbitration with display refresh
    input  wire logic              refresh_busy,
    // Status
    output logic                   big_endian,
    output logic                   profile_valid
);

    logic              bus_tick;
    logic              arb_hit;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] sel_rdata;
    logic [DATA_W-1:0] wr_swapped;
    logic              is_read;
    logic              is_write;
    logic              mem_wr_lo;
    logic              mem_wr_hi;
    logic              reg_wr_lo;
    logic              reg_wr_hi;

    // Strap capture state.
    logic              rst_seen_q;
    logic              rst_seen_d;
    logic              endian_q;
    logic              endian_d;
    logic              polarity_q;
    logic              polarity_d;
    logic              divide_q;
    logic              divide_d;
    logic              valid_q;
    logic              valid_d;

    // Access state.
    shb_state_t        state_q;
    shb_state_t        state_d;
    logic [ARB_CNT_W-1:0] arb_cnt_q;
    logic [ARB_CNT_W-1:0] arb_cnt_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              drive_q;
    logic              drive_d;
    logic              ready_q;
    logic              ready_d;
    logic              stall_oe_n_q;
    logic              stall_oe_n_d;
    logic              stall_q;
    logic              stall_d;

    shbtp_clkdiv u_clkdiv
    (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .divide_two (divide_q),
        .bus_tick   (bus_tick)
    );

    shbtp_store #(.DEPTH_W(DEPTH_W)) u_mem
    (
        .clock (clock),
        .wr_lo (mem_wr_lo),
        .wr_hi (mem_wr_hi),
        .index (port_address[DEPTH_W:1]),
        .wdata (wr_swapped),
        .rdata (mem_rdata)
    );

    shbtp_store #(.DEPTH_W(DEPTH_W)) u_reg
    (
        .clock (clock),
        .wr_lo (reg_wr_lo),
        .wr_hi (reg_wr_hi),
        .index (port_address[DEPTH_W:1]),
        .wdata (wr_swapped),
        .rdata (reg_rdata)
    );

    // Straps are sampled on the first clock after reset release, not on the reset edge itself.
    // Holding them in flops means a strap changed later takes effect only at the next reset.
    always_comb
    begin
        rst_seen_d = 1'b1;
        endian_d   = endian_q;
        polarity_d = polarity_q;
        divide_d   = divide_q;
        valid_d    = valid_q;
        if (!rst_seen_q)
        begin
            endian_d   = endian_profile_strap;
            polarity_d = stall_polarity_strap;
            divide_d   = clock_divide_strap;
            valid_d    = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rst_seen_q <= 1'b0;
            endian_q   <= ENDIAN_BIG;
            polarity_q <= STALL_ACT_HIGH;
            divide_q   <= 1'b0;
            valid_q    <= 1'b0;
        end
        else
        begin
            rst_seen_q <= rst_seen_d;
            endian_q   <= endian_d;
            polarity_q <= polarity_d;
            divide_q   <= divide_d;
            valid_q    <= valid_d;
        end
    end

    // Both read enables together mark a read; the port only ever sees 16-bit reads.
    assign is_read  = !chip_select_n && !low_read_n && !high_read_n;
    assign is_write = !chip_select_n && (!low_byte_write_n || !high_byte_write_n);
    // A busy refresh cycle owns the store, so a host access simply waits for a free tick.
    assign arb_hit  = bus_tick && !refresh_busy;

    // Big endian keeps the host's byte lanes as they are; little endian swaps them.
    assign wr_swapped = endian_q ? port_data_in
                                 : {port_data_in[BYTE_W-1:0], port_data_in[DATA_W-1:BYTE_W]};
    assign sel_rdata  = (mem_reg_select == SEL_MEMORY) ? mem_rdata : reg_rdata;

    // Writes commit once, on the cycle arbitration is won.
    // Gating on the final tick keeps a write from landing twice while the host holds its strobes.
    always_comb
    begin
        mem_wr_lo = 1'b0;
        mem_wr_hi = 1'b0;
        reg_wr_lo = 1'b0;
        reg_wr_hi = 1'b0;
        if (state_q == SHB_ARB && arb_hit && arb_cnt_q == '0 && is_write)
        begin
            if (mem_reg_select == SEL_MEMORY)
            begin
                mem_wr_lo = !low_byte_write_n;
                mem_wr_hi = !high_byte_write_n;
            end
            else
            begin
                reg_wr_lo = !low_byte_write_n;
                reg_wr_hi = !high_byte_write_n;
            end
        end
    end

    // Each access is a single cycle; the port never steps the address itself and so
    // a burst host must be told to fall back, which its chip-select timer does.
    always_comb
    begin
        state_d      = state_q;
        arb_cnt_d    = arb_cnt_q;
        rdata_d      = rdata_q;
        drive_d      = 1'b0;
        ready_d      = ready_q;
        unique case (state_q)
            SHB_IDLE:
            begin
                ready_d = 1'b0;
                if (valid_q && (is_read || is_write))
                begin
                    state_d   = SHB_ARB;
                    arb_cnt_d = ARB_CNT_W'(ARB_LAT);
                end
            end
            SHB_ARB:
            begin
                // A select that drops here is an abort: nothing is written and no answer follows.
                drive_d = is_read;
                if (chip_select_n)
                begin
                    state_d = SHB_IDLE;
                end
                else if (arb_hit)
                begin
                    if (arb_cnt_q == '0)
                    begin
                        rdata_d = endian_q ? sel_rdata
                                           : {sel_rdata[BYTE_W-1:0], sel_rdata[DATA_W-1:BYTE_W]};
                        ready_d = 1'b1;
                        state_d = SHB_DONE;
                    end
                    else
                    begin
                        arb_cnt_d = arb_cnt_q - 1'b1;
                    end
                end
            end
            SHB_DONE:
            begin
                // Acknowledge stands one cycle, then the port waits for the select to drop.
                drive_d = is_read;
                ready_d = 1'b0;
                state_d = chip_select_n ? SHB_IDLE : SHB_HOLD;
            end
            SHB_HOLD:
            begin
                drive_d = is_read;
                if (chip_select_n)
                begin
                    state_d = SHB_IDLE;
                end
            end
        endcase
    end

    // Stall active while selected and ready; polarity follows the strap.
    // The enable follows the next state so the shared line is let go as soon as the access ends.
    always_comb
    begin
        stall_oe_n_d = chip_select_n || state_d == SHB_IDLE;
        stall_d      = polarity_q ? ready_d : ~ready_d;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q      <= SHB_IDLE;
            arb_cnt_q    <= '0;
            rdata_q      <= DATA_RST;
            drive_q      <= 1'b0;
            ready_q      <= 1'b0;
            stall_oe_n_q <= 1'b1;
            stall_q      <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            arb_cnt_q    <= arb_cnt_d;
            rdata_q      <= rdata_d;
            drive_q      <= drive_d;
            ready_q      <= ready_d;
            stall_oe_n_q <= stall_oe_n_d;
            stall_q      <= stall_d;
        end
    end

    assign port_data_out  = rdata_q;
    assign port_data_oe_n = ~drive_q;
    assign stall_out      = stall_q;
    assign stall_oe_n     = stall_oe_n_q;
    assign big_endian     = endian_q;
    assign profile_valid  = valid_q;

endmodule

/* shbtp_pkg.sv */
package shbtp_pkg;

    // Host port geometry.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // Straps: endian 1 = big endian, polarity 1 = stall active high, divide 1 = 2:1.
    localparam logic ENDIAN_BIG       = 1'b1;
    localparam logic STALL_ACT_HIGH   = 1'b1;
    localparam logic DIVIDE_TWO       = 1'b1;

    // Default internal arbitration latency, in internal bus clock ticks.
    localparam int ARB_LAT_DEF  = 2;
    localparam int ARB_CNT_W    = 4;

    // Memory/register select level that routes to the display buffer.
    localparam logic SEL_MEMORY = 1'b1;

    // Reset values.
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [3:0]
    {
        SHB_IDLE  = 4'b0001,
        SHB_ARB   = 4'b0010,
        SHB_DONE  = 4'b0100,
        SHB_HOLD  = 4'b1000
    } shb_state_t;

endpackage

/* shbtp_clkdiv.sv */
`timescale 1ns/1ps
module shbtp_clkdiv
    import shbtp_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Configuration
    input  wire logic divide_two,
    // Internal bus clock tick
    output logic      bus_tick
);

    logic phase_q;
    logic phase_d;

    // Internal bus clock is a tick on every edge (1:1) or every second edge (2:1).
    always_comb
    begin
        phase_d  = divide_two ? ~phase_q : 1'b1;
        bus_tick = divide_two ? phase_q : 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            phase_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

endmodule

/* shbtp_store.sv */
`timescale 1ns/1ps
module shbtp_store
    import shbtp_pkg::*;
#(
    parameter int DEPTH_W = 6
)
(
    // Clock
    input  wire logic              clock,
    // Access
    input  wire logic              wr_lo,
    input  wire logic              wr_hi,
    input  wire logic [DEPTH_W-1:0] index,
    input  wire logic [DATA_W-1:0]  wdata,
    output logic      [DATA_W-1:0]  rdata
);

    // Small backing store standing in for the buffer or register bank.
    logic [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];

    assign rdata = mem[index];

    always_ff @(posedge clock)
    begin
        if (wr_lo)
        begin
            mem[index][BYTE_W-1:0] <= wdata[BYTE_W-1:0];
        end
        if (wr_hi)
        begin
            mem[index][DATA_W-1:BYTE_W] <= wdata[DATA_W-1:BYTE_W];
        end
    end

endmodule

/* shbtp_port_props.sv */
`timescale 1ns/1ps
module shbtp_port_props
    import shbtp_pkg::*;
(
    // Watched ports
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic low_read_n,
    input wire logic stall_out,
    input wire logic stall_oe_n,
    input wire logic port_data_oe_n,
    input wire logic profile_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    no_early_a: assert property (!profile_valid |-> stall_oe_n && !stall_out)
        else $error("access answered before profile valid");
    ack_pulse_a: assert property (stall_out |=> !stall_out)
        else $error("acknowledge longer than one cycle");
    ack_driven_a: assert property (stall_out |-> !stall_oe_n)
        else $error("acknowledge on undriven line");
    stall_release_a: assert property (chip_select_n [*2] |-> stall_oe_n)
        else $error("stall line driven while deselected");
    data_release_a: assert property (chip_select_n [*2] |-> port_data_oe_n)
        else $error("data bus driven while deselected");
    min_wait_a: assert property ($fell(chip_select_n) |-> !stall_out [*4])
        else $error("acknowledge before arbitration");
    ack_cause_a: assert property ($rose(stall_out) |-> !$past(chip_select_n, 4) && !chip_select_n)
        else $error("acknowledge without selected access");
    read_drive_a: assert property ($rose(stall_out) && !low_read_n |-> !port_data_oe_n)
        else $error("read acknowledged with data not driven");

    cover property ($rose(profile_valid));
    cover property ($rose(stall_out) && !low_read_n);
    cover property ($rose(stall_out) && low_read_n);
endmodule

bind shbtp_port shbtp_port_props u_props (.clock, .sys_rst, .chip_select_n, .low_read_n,
    .stall_out, .stall_oe_n, .port_data_oe_n, .profile_valid);

/* shbtp_host_model.sv */
`timescale 1ns/1ps
module shbtp_host_model
    import shbtp_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Answer from the port
    input  wire logic              stall_out,
    input  wire logic              stall_oe_n,
    // Request to the port
    output logic                   chip_select_n,
    output logic [ADDR_W-1:0]      port_address,
    output logic                   mem_reg_select,
    output logic                   low_byte_write_n,
    output logic                   high_byte_write_n,
    output logic                   read_n,
    output logic [DATA_W-1:0]      host_data,
    output logic                   host_drv
);
    logic relaxed  = 1'b0;
    logic ext_hold = 1'b0;
    logic fresh    = 1'b1;

    initial
    begin
        chip_select_n = 1'b1;
        port_address = '0;
        mem_reg_select = 1'b0;
        low_byte_write_n = 1'b1;
        high_byte_write_n = 1'b1;
        read_n = 1'b1;
        host_data = 16'h0000;
        host_drv = 1'b0;
    end

    // Timer options for the accesses that follow; the next access counts as the first one.
    task automatic setup(input logic rlx, input logic eh);
        relaxed = rlx;
        ext_hold = eh;
        fresh = 1'b1;
    endtask

    // Bursts never reach the port: the timer inhibits them, so every access is one single cycle,
    // 16-bit for reads and 8- or 16-bit for writes by byte enable, ended by the target acknowledge.
    task automatic access(input logic wr, input logic [1:0] be, input logic [ADDR_W-1:0] a,
                          input logic sel, input logic [DATA_W-1:0] d, output int lat);
        lat = 0;
        if (ext_hold && fresh)
        begin
            @(posedge clock);
            #1;
        end
        fresh = 1'b0;
        port_address = a;
        mem_reg_select = sel;
        host_data = d;
        host_drv = wr;
        if (relaxed)
        begin
            @(posedge clock);
            #1;
        end
        // The relaxed timer holds select back a whole clock,
        // so the port sees select one rising edge later.
        chip_select_n = 1'b0;
        low_byte_write_n = !(wr && be[0]);
        high_byte_write_n = !(wr && be[1]);
        read_n = wr;
        do
        begin
            @(negedge clock);
            lat++;
        end while (!(stall_out === 1'b1 && stall_oe_n === 1'b0) && lat < 64);
        @(posedge clock);
        #1;
        // Default negate timing: select and write strobes let go only after the acknowledge edge.
        chip_select_n = 1'b1;
        low_byte_write_n = 1'b1;
        high_byte_write_n = 1'b1;
        read_n = 1'b1;
        host_drv = 1'b0;
        // A released bus must not keep showing the old value.
        host_data = ~d;
        @(posedge clock);
        #1;
    endtask
endmodule

/* shbtp_port_bench.sv */
`timescale 1ns/1ps
module shbtp_port_bench;
    import shbtp_pkg::*;
    logic              clock = 1'b0;
    logic              sys_rst = 1'b1;
    logic              endian = ENDIAN_BIG;
    logic              divide = 1'b0;
    logic              refresh_busy = 1'b0;
    logic              quiet = 1'b1;
    logic              cs_n, msel, lo_wr_n, hi_wr_n, rd_n, host_drv, data_oe_n, stall_out, stall_oe_n, big_e, pvalid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_data, data_out;
    wire  [DATA_W-1:0] data_in = data_oe_n ? host_data : data_out;
    int                err_count = 0, compares = 0, seed = 32'h5794, cyc = 0, lat, lat_fast;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] exp_q [$];

    always #2.5 clock = ~clock;

    shbtp_port u_shbtp_port (.clock(clock), .sys_rst(sys_rst), .endian_profile_strap(endian),
        .stall_polarity_strap(1'b1), .clock_divide_strap(divide), .chip_select_n(cs_n),
        .port_address(addr), .mem_reg_select(msel), .low_byte_write_n(lo_wr_n),
        .high_byte_write_n(hi_wr_n), .low_read_n(rd_n), .high_read_n(rd_n),
        .bus_start_unused(1'b1), .port_data_in(data_in), .port_data_out(data_out),
        .port_data_oe_n(data_oe_n), .stall_out(stall_out), .stall_oe_n(stall_oe_n),
        .refresh_busy(refresh_busy), .big_endian(big_e), .profile_valid(pvalid));

    shbtp_host_model u_host (.clock(clock), .stall_out(stall_out), .stall_oe_n(stall_oe_n),
        .chip_select_n(cs_n), .port_address(addr), .mem_reg_select(msel), .low_byte_write_n(lo_wr_n),
        .high_byte_write_n(hi_wr_n), .read_n(rd_n), .host_data(host_data), .host_drv(host_drv));

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk_bit(pvalid, 1'b1);
        chk_bit(big_e, endian);
    endtask

    // The model store holds words as the port stores them; little endian swaps the lanes.
    task automatic wr(input logic s, input logic [ADDR_W-1:0] a, input logic [1:0] b, input logic [DATA_W-1:0] d);
        int k;
        logic [DATA_W-1:0] v;
        k = {s, a[6:1]};
        v = endian ? d : {d[7:0], d[15:8]};
        u_host.access(1'b1, b, a, s, d, lat);
        chk_bit(lat < 64, 1'b1);
        if (b[0])
            mem[k][7:0] = v[7:0];
        if (b[1])
            mem[k][15:8] = v[15:8];
    endtask

    task automatic rd(input logic s, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = mem[{s, a[6:1]}];
        exp_q.push_back(endian ? v : {v[7:0], v[15:8]});
        u_host.access(1'b0, 2'b11, a, s, 16'h0000, lat);
        chk_bit(lat < 64, 1'b1);
    endtask

    // Reads are judged in the one cycle that the acknowledge stands.
    always @(negedge clock)
    begin
        if (stall_out === 1'b1 && stall_oe_n === 1'b0 && rd_n === 1'b0)
        begin
            if (exp_q.size() > 0)
                chk(data_out, exp_q.pop_front());
            else
            begin
                err_count++;
                $display("[ERR] %0t read answered with nothing expected", $time);
            end
        end
        if (host_drv === 1'b1)
            chk_bit(data_oe_n, 1'b1);
    end

    always @(posedge clock)
    begin
        #1;
        refresh_busy = quiet ? 1'b0 : (($random(seed) & 3) == 0);
    end

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            $display("[ERR] %0t run hung", $time);
            report_and_stop();
        end
    end

    initial
    begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [31:0]       r;
        do_reset();
        $display("test straps 1:1 done");
        quiet = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            a = ADDR_W'($random(seed));
            d = DATA_W'($random(seed));
            r = $random(seed);
            u_host.setup(r[0], r[1]);
            wr(1'b0, a, 2'b11, d);
            wr(1'b1, a, 2'b11, ~d);
            // Neighbour address shares the word: only one byte lane may change.
            wr(i[0], a ^ 18'h00001, i[1] ? 2'b01 : 2'b10, d ^ 16'h5a5a);
            rd(1'b0, a);
            rd(1'b1, a);
        end
        $display("test data with refresh done");
        quiet = 1'b1;
        u_host.setup(1'b0, 1'b0);
        rd(1'b0, a);
        lat_fast = lat;
        divide = 1'b1;
        endian = 1'b0;
        do_reset();
        // The store keeps its words across reset, so the old word now reads byte swapped.
        rd(1'b0, a);
        wr(1'b0, a, 2'b01, 16'hc3a5);
        rd(1'b0, a);
        chk_bit(lat > lat_fast, 1'b1);
        $display("test divide strap done");
        repeat (4) @(posedge clock);
        chk_bit(exp_q.size() == 0, 1'b1);
        report_and_stop();
    end
endmodule
